// ===== verif/adcr_host_model.sv
// host controller model issuing command bytes and word transfers
`timescale 1ns/1ps
`default_nettype none

module adcr_host_model (
   input  wire logic        mclk,
   input  wire logic        rd_valid,
   input  wire logic [23:0] rd_data,
   output logic             cmd_valid,
   output logic [7:0]       cmd_byte,
   output logic             xfer_valid,
   output logic [23:0]      xfer_wdata
);
   // idle lines at time zero
   initial begin
      cmd_valid  = 1'b0;
      cmd_byte   = 8'h00;
      xfer_valid = 1'b0;
      xfer_wdata = 24'h00_0000;
   end

   // one command byte, then released lines show the inverse
   task automatic send_cmd(input logic [7:0] b);
      @(negedge mclk);
      cmd_valid <= 1'b1;
      cmd_byte  <= b;
      @(negedge mclk);
      cmd_valid <= 1'b0;
      cmd_byte  <= ~b;
   endtask : send_cmd

   // write: command with write-enable low, then exactly one word
   task automatic wr(input logic [3:0] a, input logic [23:0] d);
      send_cmd({4'h0, a});
      xfer_valid <= 1'b1;
      xfer_wdata <= d;
      @(negedge mclk);
      xfer_valid <= 1'b0;
      xfer_wdata <= ~d;
   endtask : wr

   // transfer strobe with no command before it, must be ignored
   task automatic stray_xfer(input logic [23:0] d);
      @(negedge mclk);
      xfer_valid <= 1'b1;
      xfer_wdata <= d;
      @(negedge mclk);
      xfer_valid <= 1'b0;
      xfer_wdata <= ~d;
   endtask : stray_xfer

   // read: command with read bit set, one transfer, bounded wait for answer
   task automatic rd(input logic [3:0] a, output logic [23:0] d, output logic ok);
      send_cmd({4'h4, a});
      xfer_valid <= 1'b1;
      @(negedge mclk);
      xfer_valid <= 1'b0;
      ok = 1'b0;
      d  = 24'h00_0000;
      for (int i = 0; i < 4 && !ok; i++) begin
         if (rd_valid === 1'b1) begin
            d  = rd_data;
            ok = 1'b1;
         end else begin
            @(negedge mclk);
         end
      end
   endtask : rd
endmodule : adcr_host_model

`default_nettype wire

// ===== verif/adcr_regs_tb.sv
// self-checking bench for the result and calibration register bank
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
   $display("BAD t=%0t got %h exp %h", $time, g, e); end end

module adcr_regs_tb;
   import adcr_pkg::*;
   localparam logic [7:0] TB_PART_ID = 8'h3C; // arbitrary value
   logic              mclk, rst, cmd_valid, xfer_valid, rd_valid, cmd_expected;
   logic [7:0]        cmd_byte;
   logic [23:0]       xfer_wdata, rd_data, main_result;
   logic [15:0]       aux_result;
   adcr_main_sample_t main_filter;
   adcr_aux_sample_t  aux_filter;
   int                failures, checked;

   adcr_regs #(.PART_ID(TB_PART_ID)) dut (
      .mclk(mclk), .rst(rst), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
      .xfer_valid(xfer_valid), .xfer_wdata(xfer_wdata), .main_filter(main_filter),
      .aux_filter(aux_filter), .rd_data(rd_data), .rd_valid(rd_valid),
      .cmd_expected(cmd_expected), .main_result(main_result), .aux_result(aux_result));

   adcr_host_model host (
      .mclk(mclk), .rd_valid(rd_valid), .rd_data(rd_data), .cmd_valid(cmd_valid),
      .cmd_byte(cmd_byte), .xfer_valid(xfer_valid), .xfer_wdata(xfer_wdata));

   // 20 MHz clock
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // verdict and end of run
   task automatic final_report();
      if (failures == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : final_report

   // masked register read against expected value
   task automatic rc(input logic [3:0] a, input logic [23:0] m, input logic [23:0] e);
      logic [23:0] d;
      logic        ok;
      host.rd(a, d, ok);
      if (!ok) begin
         failures++;
         $display("BAD t=%0t no read answer", $time);
         final_report();
      end else begin
         `CHK(d & m, e)
      end
   endtask : rc

   // one main filter sample, data inverted once released
   task automatic mf(input logic [23:0] raw);
      @(negedge mclk);
      main_filter <= '{1'b1, raw};
      @(negedge mclk);
      main_filter <= '{1'b0, ~raw};
   endtask : mf

   // one aux filter sample
   task automatic af(input logic [15:0] raw);
      @(negedge mclk);
      aux_filter <= '{1'b1, raw};
      @(negedge mclk);
      aux_filter <= '{1'b0, ~raw};
   endtask : af

   // hang guard
   initial begin
      repeat (20000) @(posedge mclk);
      failures++;
      $display("BAD t=%0t run limit reached", $time);
      final_report();
   end

   // main sequence
   initial begin
      rst = 1'b1;
      main_filter = '0;
      aux_filter = '0;
      failures = 0;
      checked = 0;
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      rst = 1'b0;
      `CHK(main_result, 24'h00_0000)
      `CHK(aux_result, 16'h0000)
      `CHK(cmd_expected, 1'b1)
      rc(ADDR_MAIN_OFF, 24'hFF_FFFF, 24'h80_0000);
      rc(ADDR_AUX_OFF, 24'h00_FFFF, 24'h00_8000);
      rc(ADDR_MAIN_GAIN, 24'hF0_000F, 24'h50_0005);
      rc(ADDR_AUX_GAIN, 24'h00_FF00, 24'h00_5900);
      rc(ADDR_ID, 24'hFF_FFFF, {16'h0000, TB_PART_ID});
      rc(ADDR_TEST1, 24'h00_FFFF, 24'h00_0000);
      rc(ADDR_TEST2, 24'h00_FFFF, 24'h00_0000);
      rc(ADDR_MAIN_DATA, 24'hFF_FFFF, 24'h00_0000);
      rc(ADDR_AUX_DATA, 24'hFF_FFFF, 24'h00_0000);
      // writes to read-only places leave them alone
      host.wr(ADDR_ID, 24'h00_00FF);
      rc(ADDR_ID, 24'hFF_FFFF, {16'h0000, TB_PART_ID});
      host.wr(ADDR_MAIN_DATA, 24'h12_3456);
      rc(ADDR_MAIN_DATA, 24'hFF_FFFF, 24'h00_0000);
      rc(4'hE, 24'hFF_FFFF, 24'h00_0000);
      // command with write-enable high is not taken
      host.send_cmd(8'hCF);
      `CHK(cmd_expected, 1'b1)
      // test register round trip, then restored
      host.wr(ADDR_TEST1, 24'h00_1234);
      rc(ADDR_TEST1, 24'h00_FFFF, 24'h00_1234);
      host.wr(ADDR_TEST1, 24'h00_0000);
      // distinct coefficients per channel pair, 24-bit results
      for (int p = 0; p < 3; p++) begin
         host.wr(ADDR_MAIN_CTRL, 24'(8'h47 | (p << 4)));
         host.wr(ADDR_MAIN_OFF, 24'(24'h80_0000 + (p + 1) * 16));
         host.wr(ADDR_MAIN_GAIN, 24'(24'h40_0000 >> p));
      end
      for (int p = 0; p < 3; p++) begin
         host.wr(ADDR_MAIN_CTRL, 24'(8'h47 | (p << 4)));
         rc(ADDR_MAIN_OFF, 24'hFF_FFFF, 24'(24'h80_0000 + (p + 1) * 16));
         rc(ADDR_MAIN_GAIN, 24'hFF_FFFF, 24'(24'h40_0000 >> p));
         mf(24'(24'h80_1000 + (p + 1) * 16));
         `CHK(main_result, 24'(24'h80_0000 + (24'h00_1000 >> p)))
      end
      rc(ADDR_MAIN_DATA, 24'hFF_FFFF, 24'h80_0400);
      host.wr(ADDR_MAIN_CTRL, 24'h00_0027);
      rc(ADDR_MAIN_DATA, 24'hFF_FFFF, 24'h00_8004);
      host.wr(ADDR_MAIN_CTRL, 24'h00_0037);
      rc(ADDR_MAIN_OFF, 24'hFF_FFFF, 24'h80_0030);
      // aux correction with unity gain
      host.wr(ADDR_AUX_GAIN, 24'h00_4000);
      host.wr(ADDR_AUX_OFF, 24'h00_8020);
      rc(ADDR_AUX_GAIN, 24'h00_FFFF, 24'h00_4000);
      rc(ADDR_AUX_OFF, 24'h00_FFFF, 24'h00_8020);
      // transfer without command leaves state and registers alone
      host.stray_xfer(24'h00_1111);
      `CHK(cmd_expected, 1'b1)
      rc(ADDR_AUX_OFF, 24'h00_FFFF, 24'h00_8020);
      af(16'h4321);
      `CHK(aux_result, 16'h4301)
      rc(ADDR_AUX_DATA, 24'hFF_FFFF, 24'h00_4301);
      final_report();
   end
endmodule : adcr_regs_tb

`default_nettype wire

// ===== verilog/adcr_pkg.sv
// shared constants and types for the conversion result and calibration register bank
package adcr_pkg;
   // register addresses carried in the low nibble of the command byte
   localparam logic [3:0] ADDR_STATUS     = 4'h0;
   localparam logic [3:0] ADDR_MAIN_CTRL  = 4'h2;
   localparam logic [3:0] ADDR_MAIN_DATA  = 4'h5;
   localparam logic [3:0] ADDR_AUX_DATA   = 4'h6;
   localparam logic [3:0] ADDR_MAIN_OFF   = 4'h8;
   localparam logic [3:0] ADDR_AUX_OFF    = 4'h9;
   localparam logic [3:0] ADDR_MAIN_GAIN  = 4'hA;
   localparam logic [3:0] ADDR_AUX_GAIN   = 4'hB;
   localparam logic [3:0] ADDR_TEST1      = 4'hC;
   localparam logic [3:0] ADDR_TEST2      = 4'hD;
   localparam logic [3:0] ADDR_ID         = 4'hF;

   // command byte field positions
   localparam int CMD_WEN_N_BIT = 7;
   localparam int CMD_READ_BIT  = 6;
   localparam int CMD_ADDR_LSB  = 0;

   // main converter control fields
   localparam int CTRL_WORD_LENGTH_BIT = 6;
   localparam int CTRL_PAIR_HIGH_BIT   = 5;
   localparam int CTRL_PAIR_LOW_BIT    = 4;

   // values after reset
   localparam logic [7:0]  MAIN_CTRL_RST   = 8'h07;
   localparam logic [23:0] MAIN_RESULT_RST = 24'h00_0000;
   localparam logic [15:0] AUX_RESULT_RST  = 16'h0000;
   localparam logic [23:0] MAIN_OFF_RST    = 24'h80_0000;
   localparam logic [15:0] AUX_OFF_RST     = 16'h8000;
   localparam logic [7:0]  AUX_GAIN_UPPER  = 8'h59;
   localparam logic [15:0] TEST_RST        = 16'h0000;

   // number of channel pairs with their own main coefficients
   localparam int MAIN_PAIRS = 3;

   // gain coefficient binary point positions
   localparam int MAIN_GAIN_SHIFT = 22;
   localparam int AUX_GAIN_SHIFT  = 14;

   typedef struct packed {
      logic        valid;
      logic [23:0] data;
   } adcr_main_sample_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] data;
   } adcr_aux_sample_t;

   typedef enum logic {
      ST_WAIT_CMD,
      ST_WAIT_XFER
   } adcr_state_t;
endpackage : adcr_pkg

// ===== verilog/adcr_regs.sv
// result and calibration register bank with offset and gain correction
`timescale 1ns/1ps
`default_nettype none

// offset and gain correction of one filter output, saturated to unsigned range
module adcr_cal #(
   parameter int W     = 24,
   parameter int SHIFT = 22
) (
   input  wire logic [W-1:0] raw,
   input  wire logic [W-1:0] offset,
   input  wire logic [W-1:0] gain,
   output logic      [W-1:0] corrected
);
   logic signed [W:0]     diff;
   logic signed [2*W+1:0] prod;
   logic signed [2*W+1:0] sum;
   logic signed [2*W+1:0] mid;
   logic signed [2*W+1:0] top;

   // subtract offset, scale by gain, recentre on midscale
   always_comb begin
      mid       = (2*W+2)'(1) <<< (W-1);
      top       = ((2*W+2)'(1) <<< W) - (2*W+2)'(1);
      diff      = $signed({1'b0, raw}) - $signed({1'b0, offset});
      prod      = diff * $signed({1'b0, gain});
      sum       = (prod >>> SHIFT) + mid;
      corrected = (sum < 0) ? '0 : (sum > top) ? '1 : sum[W-1:0];
   end
endmodule : adcr_cal

module adcr_regs
   import adcr_pkg::*;
#(
   parameter logic [23:0] MAIN_GAIN_FACTORY = 24'h55_5555,
   parameter logic [7:0]  AUX_GAIN_LOW      = 8'h00,
   parameter logic [7:0]  PART_ID           = 8'hA5  // arbitrary value
) (
   input  wire logic                       mclk,
   input  wire logic                       rst,
   input  wire logic                       cmd_valid,
   input  wire logic [7:0]                 cmd_byte,
   input  wire logic                       xfer_valid,
   input  wire logic [23:0]                xfer_wdata,
   input  wire adcr_pkg::adcr_main_sample_t main_filter,
   input  wire adcr_pkg::adcr_aux_sample_t  aux_filter,
   output logic [23:0]                     rd_data,
   output logic                            rd_valid,
   output logic                            cmd_expected,
   output logic [23:0]                     main_result,
   output logic [15:0]                     aux_result
);
   import adcr_pkg::*;

   adcr_state_t state;
   logic        cmd_read;
   logic [3:0]  cmd_addr;
   logic [7:0]  main_converter_control;
   logic [23:0] main_offset_coefficient [MAIN_PAIRS];
   logic [23:0] main_gain_coefficient   [MAIN_PAIRS];
   logic [15:0] aux_offset_coefficient;
   logic [15:0] aux_gain_coefficient;
   logic [15:0] factory_test_controls [2];
   logic        word_length_select;
   logic        main_pair_select_high;
   logic        main_pair_select_low;
   logic [1:0]  pair;
   logic [23:0] next_rd_data;
   logic [23:0] main_corr;
   logic [15:0] aux_corr;
   logic        do_write;
   logic        do_read;

   // control fields and pair index, code three folds onto the last pair
   assign word_length_select    = main_converter_control[CTRL_WORD_LENGTH_BIT];
   assign main_pair_select_high = main_converter_control[CTRL_PAIR_HIGH_BIT];
   assign main_pair_select_low  = main_converter_control[CTRL_PAIR_LOW_BIT];
   assign pair = (main_pair_select_high && main_pair_select_low) ? 2'd2
                 : {main_pair_select_high, main_pair_select_low};

   assign do_write = (state == ST_WAIT_XFER) && xfer_valid && !cmd_read;
   assign do_read  = (state == ST_WAIT_XFER) && xfer_valid && cmd_read;

   // correction of main filter output with the selected pair coefficients
   adcr_cal #(.W(24), .SHIFT(MAIN_GAIN_SHIFT)) u_main_cal (
      .raw       (main_filter.data),
      .offset    (main_offset_coefficient[pair]),
      .gain      (main_gain_coefficient[pair]),
      .corrected (main_corr)
   );

   // correction of aux filter output
   adcr_cal #(.W(16), .SHIFT(AUX_GAIN_SHIFT)) u_aux_cal (
      .raw       (aux_filter.data),
      .offset    (aux_offset_coefficient),
      .gain      (aux_gain_coefficient),
      .corrected (aux_corr)
   );

   // command then one transfer; a command byte with the write-enable-low bit set is ignored
   always_ff @(posedge mclk) begin
      if (rst) begin
         state    <= ST_WAIT_CMD;
         cmd_read <= 1'b0;
         cmd_addr <= 4'h0;
      end else begin
         case (state)
            ST_WAIT_CMD: begin
               if (cmd_valid && !cmd_byte[CMD_WEN_N_BIT]) begin
                  cmd_read <= cmd_byte[CMD_READ_BIT];
                  cmd_addr <= cmd_byte[CMD_ADDR_LSB +: 4];
                  state    <= ST_WAIT_XFER;
               end
            end
            ST_WAIT_XFER: begin
               if (xfer_valid) begin
                  state <= ST_WAIT_CMD;
               end
            end
            default: begin
               state <= ST_WAIT_CMD;
            end
         endcase
      end
   end

   // interface ready for a command byte
   always_ff @(posedge mclk) begin
      if (rst) begin
         cmd_expected <= 1'b1;
      end else begin
         cmd_expected <= (state == ST_WAIT_CMD) ? !(cmd_valid && !cmd_byte[CMD_WEN_N_BIT]) : xfer_valid;
      end
   end

   // newest corrected conversion results, not writable by host
   always_ff @(posedge mclk) begin
      if (rst) begin
         main_result <= MAIN_RESULT_RST;
         aux_result  <= AUX_RESULT_RST;
      end else begin
         if (main_filter.valid) begin
            main_result <= main_corr;
         end
         if (aux_filter.valid) begin
            aux_result <= aux_corr;
         end
      end
   end

   // main control register
   always_ff @(posedge mclk) begin
      if (rst) begin
         main_converter_control <= MAIN_CTRL_RST;
      end else if (do_write && cmd_addr == ADDR_MAIN_CTRL) begin
         main_converter_control <= xfer_wdata[7:0];
      end
   end

   // main coefficient banks, host reaches the selected pair only
   always_ff @(posedge mclk) begin
      if (rst) begin
         for (int i = 0; i < MAIN_PAIRS; i++) begin
            main_offset_coefficient[i] <= MAIN_OFF_RST;
            main_gain_coefficient[i]   <= MAIN_GAIN_FACTORY;
         end
      end else if (do_write) begin
         if (cmd_addr == ADDR_MAIN_OFF) begin
            main_offset_coefficient[pair] <= xfer_wdata;
         end
         if (cmd_addr == ADDR_MAIN_GAIN) begin
            main_gain_coefficient[pair] <= xfer_wdata;
         end
      end
   end

   // aux coefficients
   always_ff @(posedge mclk) begin
      if (rst) begin
         aux_offset_coefficient <= AUX_OFF_RST;
         aux_gain_coefficient   <= {AUX_GAIN_UPPER, AUX_GAIN_LOW};
      end else if (do_write) begin
         if (cmd_addr == ADDR_AUX_OFF) begin
            aux_offset_coefficient <= xfer_wdata[15:0];
         end
         if (cmd_addr == ADDR_AUX_GAIN) begin
            aux_gain_coefficient <= xfer_wdata[15:0];
         end
      end
   end

   // test registers, kept for readback only
   always_ff @(posedge mclk) begin
      if (rst) begin
         factory_test_controls[0] <= TEST_RST;
         factory_test_controls[1] <= TEST_RST;
      end else if (do_write) begin
         if (cmd_addr == ADDR_TEST1) begin
            factory_test_controls[0] <= xfer_wdata[15:0];
         end
         if (cmd_addr == ADDR_TEST2) begin
            factory_test_controls[1] <= xfer_wdata[15:0];
         end
      end
   end

   // read multiplexer, short words sit in low bits
   always_comb begin
      next_rd_data = 24'h00_0000;
      case (cmd_addr)
         ADDR_MAIN_CTRL: next_rd_data = {16'h0000, main_converter_control};
         ADDR_MAIN_DATA: next_rd_data = word_length_select ? main_result
                                        : {8'h00, main_result[23:8]};
         ADDR_AUX_DATA:  next_rd_data = {8'h00, aux_result};
         ADDR_MAIN_OFF:  next_rd_data = main_offset_coefficient[pair];
         ADDR_AUX_OFF:   next_rd_data = {8'h00, aux_offset_coefficient};
         ADDR_MAIN_GAIN: next_rd_data = main_gain_coefficient[pair];
         ADDR_AUX_GAIN:  next_rd_data = {8'h00, aux_gain_coefficient};
         ADDR_TEST1:     next_rd_data = {8'h00, factory_test_controls[0]};
         ADDR_TEST2:     next_rd_data = {8'h00, factory_test_controls[1]};
         ADDR_ID:        next_rd_data = {16'h0000, PART_ID};
         default:        next_rd_data = 24'h00_0000;
      endcase
   end

   // read answer one cycle after the transfer strobe
   always_ff @(posedge mclk) begin
      if (rst) begin
         rd_data  <= 24'h00_0000;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= do_read;
         if (do_read) begin
            rd_data <= next_rd_data;
         end
      end
   end

   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   logic [3:0] last_addr;
   logic       last_word_length;
   always_ff @(posedge mclk) begin
      last_addr        <= cmd_addr;
      last_word_length <= word_length_select;
   end

   a_main_rst_zero: assert property (@(posedge mclk) disable iff (1'b0)
      rst |=> main_result == MAIN_RESULT_RST) else $error("main result not zero after reset");
   a_aux_rst_zero: assert property (@(posedge mclk) disable iff (1'b0)
      rst |=> aux_result == AUX_RESULT_RST) else $error("aux result not zero after reset");
   a_main_capture: assert property (main_filter.valid |=> main_result == $past(main_corr))
      else $error("main result missed a sample");
   a_aux_hold: assert property (!aux_filter.valid |=> $stable(aux_result))
      else $error("aux result changed without sample");
   a_off_rst_mid: assert property (@(posedge mclk) disable iff (1'b0)
      rst |=> main_offset_coefficient[2] == MAIN_OFF_RST && aux_offset_coefficient == AUX_OFF_RST)
      else $error("offset not midscale after reset");
   a_off_pair_read: assert property (do_read && cmd_addr == ADDR_MAIN_OFF
      |=> rd_valid && rd_data == $past(main_offset_coefficient[pair])) else $error("wrong pair offset read");
   a_gain_rst_val: assert property (@(posedge mclk) disable iff (1'b0)
      rst |=> main_gain_coefficient[0] == MAIN_GAIN_FACTORY) else $error("main gain reset wrong");
   a_gain_pair_keep: assert property (do_write && cmd_addr == ADDR_MAIN_GAIN && pair == 2'd0
      |=> $stable(main_gain_coefficient[1]) && main_gain_coefficient[0] == $past(xfer_wdata))
      else $error("gain write hit wrong pair");
   a_aux_off_write: assert property (do_write && cmd_addr == ADDR_AUX_OFF
      |=> aux_offset_coefficient == $past(xfer_wdata[15:0])) else $error("aux offset write lost");
   a_aux_gain_rst: assert property (@(posedge mclk) disable iff (1'b0)
      rst |=> aux_gain_coefficient[15:8] == AUX_GAIN_UPPER) else $error("aux gain upper byte wrong");
   a_id_read: assert property (rd_valid && last_addr == ADDR_ID |-> rd_data == {16'h0000, PART_ID})
      else $error("id read wrong");
   a_test_rst_zero: assert property (@(posedge mclk) disable iff (1'b0)
      rst |=> factory_test_controls[0] == TEST_RST && factory_test_controls[1] == TEST_RST)
      else $error("test register not zero after reset");
   a_short_word: assert property (rd_valid && last_addr == ADDR_MAIN_DATA && !last_word_length
      |-> rd_data[23:16] == 8'h00) else $error("16-bit result not right aligned");
   a_cmd_first: assert property (state == ST_WAIT_CMD && xfer_valid
      |=> !rd_valid && $stable(aux_offset_coefficient)) else $error("transfer taken without command");

   // main scenarios reached
   c_main_read: cover property (do_read && cmd_addr == ADDR_MAIN_DATA ##1 rd_valid);
   c_gain_write: cover property (do_write && cmd_addr == ADDR_MAIN_GAIN && pair == 2'd2);
   c_short_read: cover property (do_read && cmd_addr == ADDR_MAIN_DATA && !word_length_select);
   c_stray_xfer: cover property (state == ST_WAIT_CMD && xfer_valid);
   c_aux_sample: cover property (aux_filter.valid ##1 aux_result != AUX_RESULT_RST);
endmodule : adcr_regs
`default_nettype wire
